// ---- rtl/ramp_pkg.sv ----
// constants for the ramp-time block: register map, fields, resets, timing
// assumes a 200 MHz mclk and a 32-bit Avalon-MM register port
//
// Contract
// - accel time sets ramp from zero to reference frequency; slope = ref/time
// - decel time sets ramp from reference frequency down to zero
// - reference frequency accepts 1 to 400 Hz, default 50 Hz
// - accel default 5 s small / 15 s large; decel 10 s / 30 s
// - increment selector 0: 0.1 s over 0..3600 s; 1: 0.01 s over 0..360 s
// - changing increment rescales ramp times incl. second set; restart time unchanged
// - second accel/decel times apply only while second-function select is active
// - second accel default 5 s; second decel 9999 means use second accel
// - any ramp time of 0.03 s or less runs as 0.04 s
// - with S-pattern A, set time means time to reach base frequency
// - S-pattern A above base: t = 4/9 T (f/fb)^2 + 5/9 T
// - second-function input on dedicated terminal unless a terminal code is 3
// - second-function select also enables the drive's other second functions
package ramp_pkg;
  localparam longint CLK_FREQ_HZ = 200000000;
  localparam int RAMP_MIN_TIME_MS = 40;
  localparam int RAMP_CLAMP_TIME_MS = 30;
  localparam int MS_PER_CS = 10;
  localparam int RAMP_MIN_CS = RAMP_MIN_TIME_MS / MS_PER_CS;
  localparam int RAMP_CLAMP_CS = RAMP_CLAMP_TIME_MS / MS_PER_CS;
  localparam int CYC_PER_CS_DEF = int'(CLK_FREQ_HZ / 100);
  localparam int INC_RATIO = 10;
  localparam int TIME_MAX_RAW = 36000;
  localparam int FREQ_MAX_CHZ = 40000;
  localparam int REF_MIN_HZ = 1;
  localparam int REF_MAX_HZ = 400;
  localparam int CHZ_PER_HZ = 100;
  localparam logic [15:0] DECEL_SAME_AS_ACCEL = 16'h270f;
  localparam logic [7:0] RT_FUNCTION_CODE = 8'h03;
  localparam logic [7:0] TERM_CODE_RST = 8'hff;
  localparam int TERM_COUNT = 12;
  // register indices, byte address is index times four
  localparam logic [4:0] ACCEL_PRI_IDX = 5'h00;
  localparam logic [4:0] DECEL_PRI_IDX = 5'h01;
  localparam logic [4:0] REF_FREQ_IDX = 5'h02;
  localparam logic [4:0] INC_SEL_IDX = 5'h03;
  localparam logic [4:0] ACCEL_SEC_IDX = 5'h04;
  localparam logic [4:0] DECEL_SEC_IDX = 5'h05;
  localparam logic [4:0] JOG_TIME_IDX = 5'h06;
  localparam logic [4:0] RESTART_IDX = 5'h07;
  localparam logic [4:0] BASE_FREQ_IDX = 5'h08;
  localparam logic [4:0] GAIN_A_IDX = 5'h09;
  localparam logic [4:0] GAIN_B_IDX = 5'h0a;
  localparam logic [4:0] PATTERN_IDX = 5'h0b;
  localparam logic [4:0] TARGET_IDX = 5'h0c;
  localparam logic [4:0] STATUS_IDX = 5'h0d;
  localparam logic [4:0] TERM_BASE_IDX = 5'h10;
  // status fields
  localparam int ST_FREQ_LSB = 0;
  localparam int ST_SECOND_BIT = 16;
  localparam int ST_UP_BIT = 17;
  localparam int ST_DOWN_BIT = 18;
  // reset values, times in raw increments of 0.1 s
  localparam logic [15:0] ACCEL_PRI_SMALL_RST = 16'h0032;
  localparam logic [15:0] ACCEL_PRI_LARGE_RST = 16'h0096;
  localparam logic [15:0] DECEL_PRI_SMALL_RST = 16'h0064;
  localparam logic [15:0] DECEL_PRI_LARGE_RST = 16'h012c;
  localparam logic [15:0] ACCEL_SEC_RST = 16'h0032;
  localparam logic [15:0] JOG_TIME_RST = 16'h0005;
  localparam logic [15:0] RESTART_RST = 16'h0032;
  localparam logic [8:0] REF_FREQ_RST = 9'h032;
  localparam logic [8:0] BASE_FREQ_RST = 9'h032;
  localparam logic [15:0] GAIN_RST = 16'h1388;
endpackage : ramp_pkg

// ---- rtl/term_code_mem.sv ----
// small memory for the input terminal function codes
// one write port, one read port with registered read data
`timescale 1ns/1ps
module term_code_mem #(
  parameter int DEPTH = 12,
  parameter int WIDTH = 8,
  parameter logic [7:0] RST_VAL = 8'hff
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [3:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= RST_VAL[WIDTH-1:0];
      end
      rdData <= '0;
    end else begin
      if (wrEn && (int'(wrAddr) < DEPTH)) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
    end
  end
endmodule : term_code_mem

// ---- rtl/accel_decel_time_ramp.sv ----
// output-frequency ramp generator with programmable ramp times
// assumes an Avalon-MM master with waitrequest and contact inputs synchronous to mclk
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module accel_decel_time_ramp #(
  parameter bit LARGE_CAPACITY = 1'b0,
  parameter int CYC_PER_CS = ramp_pkg::CYC_PER_CS_DEF,
  parameter int TERMINALS = ramp_pkg::TERM_COUNT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rtTerminal,
  input wire logic [TERMINALS-1:0] inputTerminals,
  output logic secondFunctionSelect,
  output logic [15:0] outputFreq,
  output logic rampActive
);
  // clamp a written value into a range
  function automatic logic [15:0] clampVal(input logic [31:0] v, input int lo, input int hi);
    if (v < 32'(lo)) begin
      return 16'(lo);
    end else if (v > 32'(hi)) begin
      return 16'(hi);
    end
    return v[15:0];
  endfunction : clampVal

  // raw time to clock cycles, with the short-time floor
  function automatic logic [47:0] timeCycles(input logic [15:0] raw, input logic fine);
    logic [19:0] cs;
    cs = fine ? 20'(raw) : 20'(raw) * 20'(ramp_pkg::INC_RATIO);
    if (cs <= 20'(ramp_pkg::RAMP_CLAMP_CS)) begin
      cs = 20'(ramp_pkg::RAMP_MIN_CS);
    end
    return 48'(cs) * 48'(CYC_PER_CS);
  endfunction : timeCycles

  logic [15:0] accelPri;
  logic [15:0] decelPri;
  logic [15:0] accelSec;
  logic [15:0] decelSec;
  logic [15:0] jogTime;
  logic [15:0] restartTime;
  logic [8:0] refFreqHz;
  logic [8:0] baseFreqHz;
  logic incSel;
  logic patternA;
  logic [15:0] gainA;
  logic [15:0] gainB;
  logic [15:0] targetFreq;
  logic [71:0] acc;
  logic lastUp;
  logic lastCurve;
  logic ack;
  logic [31:0] rdReg;
  logic rdTerm;
  logic [TERMINALS-1:0] rtFlag;
  logic [7:0] memQ;

  // bus decode: every access takes one wait cycle
  wire logic req = read | write;
  wire logic [4:0] idx = address[6:2];
  wire logic wrEn = write & ack;
  wire logic termHit = (idx >= ramp_pkg::TERM_BASE_IDX) &&
                       (idx < 5'(int'(ramp_pkg::TERM_BASE_IDX) + TERMINALS));
  wire logic [3:0] termIdx = 4'(idx - ramp_pkg::TERM_BASE_IDX);
  wire logic [15:0] wrTime = clampVal(writedata, 0, ramp_pkg::TIME_MAX_RAW);
  wire logic [15:0] wrRef = clampVal(writedata, ramp_pkg::REF_MIN_HZ, ramp_pkg::REF_MAX_HZ);
  wire logic [15:0] wrFreq = clampVal(writedata, 0, ramp_pkg::FREQ_MAX_CHZ);

  assign waitrequest = req & ~ack;
  assign readdata = rdTerm ? {24'h0, memQ} : rdReg;

  // a terminal coded 3 takes over the second-function input
  wire logic rtRemapped = |rtFlag;
  assign secondFunctionSelect = rtRemapped ? |(rtFlag & inputTerminals) : rtTerminal;
  // exported so the drive's other second functions follow it
  wire logic secondActive = secondFunctionSelect;

  // second set only while select is active
  wire logic [15:0] accelSel = secondActive ? accelSec : accelPri;
  wire logic [15:0] decelSecEff = (decelSec == ramp_pkg::DECEL_SAME_AS_ACCEL) ?
                                  accelSec : decelSec;
  wire logic [15:0] decelSel = secondActive ? decelSecEff : decelPri;

  wire logic rampUp = outputFreq < targetFreq;
  wire logic rampDown = outputFreq > targetFreq;
  wire logic [47:0] tCyc = timeCycles(rampUp ? accelSel : decelSel, incSel);

  wire logic [15:0] refC = 16'(refFreqHz) * 16'(ramp_pkg::CHZ_PER_HZ);
  wire logic [15:0] baseC = 16'(baseFreqHz) * 16'(ramp_pkg::CHZ_PER_HZ);
  wire logic aboveBase = outputFreq >= baseC;
  wire logic [15:0] slopeRef = patternA ? baseC : refC;
  // above base: df/dt = 9 fb^2 / (8 T f)
  wire logic [35:0] fbSq9 = 36'(baseC) * 36'(baseC) * 36'd9;
  wire logic [71:0] denA = 72'(outputFreq) * 72'(tCyc) * 72'd8;
  wire logic useCurve = patternA & aboveBase;
  wire logic [71:0] num = useCurve ? 72'(fbSq9) : 72'(slopeRef);
  wire logic [71:0] den = useCurve ? denA : 72'(tCyc);
  wire logic [71:0] accSum = acc + num;
  wire logic stepNow = accSum >= den;
  wire logic moving = rampUp | rampDown;
  wire logic dirFlip = moving & (rampUp != lastUp);
  // curve remainder is in other units, so crossing base restarts it
  wire logic curveEdge = useCurve != lastCurve;

  wire logic [31:0] statusWord = {13'h0, rampDown, rampUp, secondActive, outputFreq};
  wire logic [31:0] rdMux =
    (idx == ramp_pkg::ACCEL_PRI_IDX) ? {16'h0, accelPri} :
    (idx == ramp_pkg::DECEL_PRI_IDX) ? {16'h0, decelPri} :
    (idx == ramp_pkg::REF_FREQ_IDX) ? {23'h0, refFreqHz} :
    (idx == ramp_pkg::INC_SEL_IDX) ? {31'h0, incSel} :
    (idx == ramp_pkg::ACCEL_SEC_IDX) ? {16'h0, accelSec} :
    (idx == ramp_pkg::DECEL_SEC_IDX) ? {16'h0, decelSec} :
    (idx == ramp_pkg::JOG_TIME_IDX) ? {16'h0, jogTime} :
    (idx == ramp_pkg::RESTART_IDX) ? {16'h0, restartTime} :
    (idx == ramp_pkg::BASE_FREQ_IDX) ? {23'h0, baseFreqHz} :
    (idx == ramp_pkg::GAIN_A_IDX) ? {16'h0, gainA} :
    (idx == ramp_pkg::GAIN_B_IDX) ? {16'h0, gainB} :
    (idx == ramp_pkg::PATTERN_IDX) ? {31'h0, patternA} :
    (idx == ramp_pkg::TARGET_IDX) ? {16'h0, targetFreq} :
    (idx == ramp_pkg::STATUS_IDX) ? statusWord : 32'h0;

  term_code_mem #(
    .DEPTH(TERMINALS),
    .WIDTH(8),
    .RST_VAL(ramp_pkg::TERM_CODE_RST)
  ) codes (
    .mclk(mclk),
    .rst_n(rst_n),
    .wrEn(wrEn & termHit),
    .wrAddr(termIdx),
    .wrData(writedata[7:0]),
    .rdAddr(termIdx),
    .rdData(memQ)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdReg <= 32'h0;
      rdTerm <= 1'b0;
    end else begin
      ack <= req & ~ack;
      rdTerm <= read & ~ack & termHit;
      rdReg <= (read & ~ack) ? rdMux : 32'h0;
    end
  end

  // time settings
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accelPri <= LARGE_CAPACITY ? ramp_pkg::ACCEL_PRI_LARGE_RST : ramp_pkg::ACCEL_PRI_SMALL_RST;
      decelPri <= LARGE_CAPACITY ? ramp_pkg::DECEL_PRI_LARGE_RST : ramp_pkg::DECEL_PRI_SMALL_RST;
      accelSec <= ramp_pkg::ACCEL_SEC_RST;
      decelSec <= ramp_pkg::DECEL_SAME_AS_ACCEL;
      jogTime <= ramp_pkg::JOG_TIME_RST;
      restartTime <= ramp_pkg::RESTART_RST;
      incSel <= 1'b0;
    end else if (wrEn) begin
      // raw values clamp to the range of either increment
      if (idx == ramp_pkg::ACCEL_PRI_IDX) begin
        accelPri <= wrTime;
      end
      if (idx == ramp_pkg::DECEL_PRI_IDX) begin
        decelPri <= wrTime;
      end
      if (idx == ramp_pkg::ACCEL_SEC_IDX) begin
        accelSec <= wrTime;
      end
      if (idx == ramp_pkg::DECEL_SEC_IDX) begin
        decelSec <= wrTime;
      end
      if (idx == ramp_pkg::JOG_TIME_IDX) begin
        jogTime <= wrTime;
      end
      // restart time always counts in 0.1 s, so the selector never moves it
      if (idx == ramp_pkg::RESTART_IDX) begin
        restartTime <= wrTime;
      end
      // raw counts kept, so every scaled time shifts by the ratio
      if (idx == ramp_pkg::INC_SEL_IDX) begin
        incSel <= writedata[0];
      end
    end
  end

  // frequency settings
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refFreqHz <= ramp_pkg::REF_FREQ_RST;
      baseFreqHz <= ramp_pkg::BASE_FREQ_RST;
      gainA <= ramp_pkg::GAIN_RST;
      gainB <= ramp_pkg::GAIN_RST;
      patternA <= 1'b0;
      targetFreq <= 16'h0;
    end else if (wrEn) begin
      if (idx == ramp_pkg::REF_FREQ_IDX) begin
        refFreqHz <= wrRef[8:0];
      end
      if (idx == ramp_pkg::BASE_FREQ_IDX) begin
        baseFreqHz <= wrRef[8:0];
      end
      // gains only change by their own writes
      if (idx == ramp_pkg::GAIN_A_IDX) begin
        gainA <= wrFreq;
      end
      if (idx == ramp_pkg::GAIN_B_IDX) begin
        gainB <= wrFreq;
      end
      if (idx == ramp_pkg::PATTERN_IDX) begin
        patternA <= writedata[0];
      end
      if (idx == ramp_pkg::TARGET_IDX) begin
        targetFreq <= wrFreq;
      end
    end
  end

  // shadow of which terminals carry the second-function code
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rtFlag <= '0;
    end else if (wrEn && termHit) begin
      rtFlag[termIdx] <= (writedata[7:0] == ramp_pkg::RT_FUNCTION_CODE);
    end
  end

  // fractional accumulator: one 0.01 Hz step each time it overflows the period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 72'h0;
      lastUp <= 1'b0;
      lastCurve <= 1'b0;
      outputFreq <= 16'h0;
    end else begin
      lastUp <= rampUp;
      lastCurve <= useCurve;
      if (!moving || dirFlip || curveEdge) begin
        acc <= 72'h0;
      end else if (stepNow) begin
        // fixed single step, stops on target
        acc <= accSum - den;
        outputFreq <= rampUp ? outputFreq + 16'h1 : outputFreq - 16'h1;
      end else begin
        // slope may change here, frequency and remainder carry on
        acc <= accSum;
      end
    end
  end

  assign rampActive = moving;
endmodule : accel_decel_time_ramp

// ---- verif/contact_panel.sv ----
// contact model: the external second-function and general contacts
// assumes contacts settle synchronously to mclk, as the ramp block expects
`timescale 1ns/1ps
module contact_panel #(
  parameter int TERMINALS = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rtSet,
  input wire logic [TERMINALS-1:0] termSet,
  output logic rtTerminal,
  output logic [TERMINALS-1:0] inputTerminals
);
  // contacts open at reset; registered so they never glitch into the block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rtTerminal <= 1'b0;
      inputTerminals <= '0;
    end else begin
      rtTerminal <= rtSet;
      inputTerminals <= termSet;
    end
  end
endmodule : contact_panel

// ---- verif/ramp_sva.sv ----
// concurrent checks on the ramp block's ports
// assumes a single mclk domain with rst_n asynchronous active low
`timescale 1ns/1ps
module ramp_sva #(
  parameter int TERMINALS = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic rtTerminal,
  input wire logic [TERMINALS-1:0] inputTerminals,
  input wire logic secondFunctionSelect,
  input wire logic [15:0] outputFreq,
  input wire logic rampActive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_wait_first: assert property ($rose(read | write) |-> waitrequest)
    else $error("no wait cycle at request start");
  a_wait_one: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  a_wait_idle: assert property (!(read | write) |-> !waitrequest)
    else $error("waitrequest without request");
  a_rdata_zero: assert property (!(read && !waitrequest) |-> readdata == 32'h0)
    else $error("readdata not zero outside answer");
  a_unmapped_zero: assert property (read && !waitrequest && address[6:2] == 5'h0e
    |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_pad: assert property (read && !waitrequest
    && address[6:2] == ramp_pkg::STATUS_IDX |-> readdata[31:19] == 13'h0)
    else $error("status upper bits not zero");
  a_second_idle: assert property (!rtTerminal && inputTerminals == '0 |-> !secondFunctionSelect)
    else $error("second select without contact");
  a_freq_step: assert property (1'b1 |=> outputFreq == $past(outputFreq)
    || outputFreq == $past(outputFreq) + 16'h1 || outputFreq + 16'h1 == $past(outputFreq))
    else $error("frequency jumped more than one step");
  a_freq_hold: assert property (!rampActive |=> $stable(outputFreq))
    else $error("frequency moved while on target");
endmodule : ramp_sva
bind accel_decel_time_ramp ramp_sva #(.TERMINALS(TERMINALS)) u_sva (.mclk(mclk),
  .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .rtTerminal(rtTerminal),
  .inputTerminals(inputTerminals), .secondFunctionSelect(secondFunctionSelect),
  .outputFreq(outputFreq), .rampActive(rampActive));

// ---- verif/accel_decel_time_ramp_tb.sv ----
// self-checking bench for the ramp block over its Avalon-MM port
// assumes CYC_PER_CS shortened to 100 so a 0.01 s unit is 100 cycles
`timescale 1ns/1ps
module accel_decel_time_ramp_tb;
  logic mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, rtSet = 1'b0;
  logic [6:0] address = 7'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, rtTerminal, secondFunctionSelect, rampActive;
  logic [11:0] inputTerminals, termSet = 12'h000;
  logic [15:0] outputFreq;
  int nMismatch = 0, checked = 0;
  logic [4:0] rIdx [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09,
    5'h0b, 5'h0c, 5'h0e};
  logic [31:0] rVal [12] = '{32'h32, 32'h64, 32'h32, 32'h0, 32'h32, 32'h270f, 32'h32, 32'h32,
    32'h1388, 32'h0, 32'h0, 32'h0};
  always #2.5 mclk = ~mclk;
  accel_decel_time_ramp #(.LARGE_CAPACITY(1'b0), .CYC_PER_CS(100), .TERMINALS(12)) DUT (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rtTerminal(rtTerminal), .inputTerminals(inputTerminals),
    .secondFunctionSelect(secondFunctionSelect), .outputFreq(outputFreq),
    .rampActive(rampActive));
  contact_panel #(.TERMINALS(12)) panel (.mclk(mclk), .rst_n(rst_n), .rtSet(rtSet),
    .termSet(termSet), .rtTerminal(rtTerminal), .inputTerminals(inputTerminals));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [31:0] d);
    @(posedge mclk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= d;
    // only the watchdog ends a wait that never answers
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // set a target and time the ramp; expected cycles = steps * period per step
  task automatic ramp(input logic [15:0] tgt, input int exp);
    int n;
    bus(1'b1, 5'h0c, {16'h0, tgt});
    #1;
    n = 0;
    while (rampActive === 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk(outputFreq, {16'h0, tgt});
    chk({31'h0, n >= exp - 3 && n <= exp + 3}, 32'h1);
  endtask : ramp
  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrapUp
  initial begin
    repeat (60000) @(posedge mclk);
    nMismatch++;
    wrapUp();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, rIdx[i], 32'h0);
      chk(q, rVal[i]);
    end
    bus(1'b1, 5'h0e, 32'h1234);
    bus(1'b0, 5'h0e, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'h0d, 32'hffff);
    bus(1'b0, 5'h0d, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'h02, 32'h0);
    bus(1'b0, 5'h02, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 5'h02, 32'h1f4);
    bus(1'b0, 5'h02, 32'h0);
    chk(q, 32'h190);
    bus(1'b0, 5'h09, 32'h0);
    chk(q, 32'h1388);
    $display("test registers done");
    // ref 1 Hz: 100 counts; 0.1 s raw 1 is 1000 cycles, 10 per step
    bus(1'b1, 5'h02, 32'h1);
    bus(1'b1, 5'h00, 32'h1);
    bus(1'b1, 5'h01, 32'h2);
    ramp(16'h000a, 100);
    ramp(16'h0000, 200);
    bus(1'b1, 5'h03, 32'h1);
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, 5'h07, 32'h0);
    chk(q, 32'h32);
    ramp(16'h000a, 40);
    ramp(16'h0000, 40);
    bus(1'b1, 5'h00, 32'ha);
    ramp(16'h000a, 100);
    ramp(16'h0000, 40);
    bus(1'b1, 5'h03, 32'h0);
    $display("test linear ramps done");
    bus(1'b1, 5'h04, 32'h3);
    rtSet <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, secondFunctionSelect}, 32'h1);
    bus(1'b0, 5'h0d, 32'h0);
    chk({31'h0, q[16]}, 32'h1);
    ramp(16'h000a, 300);
    ramp(16'h0000, 300);
    rtSet <= 1'b0;
    bus(1'b1, 5'h13, 32'h3);
    termSet <= 12'h008;
    repeat (3) @(posedge mclk);
    chk({31'h0, secondFunctionSelect}, 32'h1);
    termSet <= 12'h000;
    repeat (3) @(posedge mclk);
    chk({31'h0, secondFunctionSelect}, 32'h0);
    $display("test second set done");
    // S-pattern A below base: base 1 Hz is the reference, not ref 50 Hz
    bus(1'b1, 5'h02, 32'h32);
    bus(1'b1, 5'h08, 32'h1);
    bus(1'b1, 5'h0b, 32'h1);
    // accel raw 10 in 0.1 s is 1 s: 100 cycles per step toward base 1 Hz
    ramp(16'h000a, 1000);
    ramp(16'h0000, 200);
    // T = 0.04 s: 400 cycles to base, 4/9 T 1.21 + 5/9 T = 437 cycles to 1.1 fb
    bus(1'b1, 5'h03, 32'h1);
    bus(1'b1, 5'h00, 32'h1);
    ramp(16'h006e, 439);
    $display("test pattern done");
    // second set at 20 cycles per step, dropped mid-ramp for 4 cycles per step
    bus(1'b1, 5'h0b, 32'h0);
    bus(1'b1, 5'h02, 32'h1);
    bus(1'b1, 5'h04, 32'h14);
    termSet <= 12'h008;
    bus(1'b1, 5'h0c, 32'h82);
    repeat (100) @(posedge mclk);
    chk(outputFreq, 32'h72);
    termSet <= 12'h000;
    ramp(16'h0082, 60);
    $display("test set switch done");
    wrapUp();
  end
endmodule : accel_decel_time_ramp_tb
